// *** common/sdl_pkg.sv ***
// Shared constants for the synchronous data link: host and position unit
// ************************************************************************
// Package
// ************************************************************************
package sdl_pkg;
    localparam int DW = 16;                  // Word width of the shared area
    localparam int AIW = 7;                  // Word index width on the link
    localparam int VW = 8;                   // Version code width, major.minor nibbles
    localparam int AREA_FIRST = 1200;        // First word of the shared area
    localparam int AREA_LAST = 1295;         // Last word of the shared area
    localparam int AREA_WORDS = AREA_LAST - AREA_FIRST + 1;
    localparam int IN_MAX = 64;              // Largest input region of one unit
    localparam int OUT_MAX = 2 ** AIW;       // Output shadow covers every index
    localparam logic [VW-1:0] VER_MIN = 8'h13;   // Oldest host version accepted
    localparam int CLK_MHZ = 250;            // Clock rate, cycles per microsecond
    localparam int CYC_MIN_US = 500;         // Shortest sync cycle, 0.5 ms
    localparam int CYC_MAX_US = 10000;       // Longest sync cycle, 10 ms
    localparam logic [15:0] CYC_RST_US = 16'h03E8;  // Sync cycle after reset, 1 ms
    localparam int CTRL_US = 500;            // Unit internal control cycle
    localparam int CTRL_CYC = CTRL_US * CLK_MHZ;
    localparam int CYC_CW = 24;              // Width of the sync period counter
    // Host register indices
    localparam logic [11:0] RA_CTRL = 12'h000;
    localparam logic [11:0] RA_CYCLE = 12'h001;
    localparam logic [11:0] RA_IN_START = 12'h002;
    localparam logic [11:0] RA_OUT_SIZE = 12'h003;
    localparam logic [11:0] RA_IN_SIZE = 12'h004;
    localparam logic [11:0] RA_STATUS = 12'h005;
    localparam logic [11:0] RA_IRQ_STAT = 12'h006;
    localparam logic [11:0] RA_IRQ_MASK = 12'h007;
    localparam logic [11:0] RA_RESTART = 12'h008;
    // Field positions
    localparam int CTRL_EN = 0;              // Synchronous control enabled
    localparam int CTRL_REG = 1;             // Unit registered in system settings
    localparam int ST_LINK = 0;
    localparam int ST_UERR = 1;
    localparam int ST_BUSY = 2;
    localparam int IRQ_DONE = 0;             // Exchange finished
    localparam int IRQ_UERR = 1;             // Unit reported an error
    localparam logic [AIW-1:0] IN_START_RST = 7'h30;  // Input part at word 1248
    localparam logic [AIW-1:0] SIZE_RST = 7'h08;
endpackage

// *** common/sdl_if.sv ***
// Link between the host processor and one position unit
`timescale 1ns/1ns
`default_nettype none
interface sdl_if;
    import sdl_pkg::*;
    logic sync;                  // Sync pulse, one cycle
    logic link_en;               // Synchronous link enabled
    logic restart;               // Collective restart pulse
    logic [VW-1:0] host_ver;     // Host version code
    logic [AIW-1:0] in_size;     // Configured input region size
    logic out_vld;               // Output word strobe
    logic [AIW-1:0] out_idx;     // Output word index in the region
    logic [DW-1:0] out_dat;
    logic out_last;              // Last output word of this exchange
    logic in_vld;                // Input word strobe
    logic [AIW-1:0] in_idx;
    logic [DW-1:0] in_dat;
    logic in_last;               // Last input word of this exchange
    logic unit_err;              // Unit in error, level
    logic unit_run;              // Unit started on the link, level
    modport host (output sync, link_en, restart, host_ver, in_size, out_vld, out_idx,
        out_dat, out_last, input in_vld, in_idx, in_dat, in_last, unit_err, unit_run);
    modport unit (input sync, link_en, restart, host_ver, in_size, out_vld, out_idx,
        out_dat, out_last, output in_vld, in_idx, in_dat, in_last, unit_err, unit_run);
endinterface
`default_nettype wire

// *** rtl/sdl_host.sv ***
// Host end: sync pacing, shared word area and register port
`timescale 1ns/1ns
`default_nettype none
module sdl_host
    import sdl_pkg::*;
#(
    parameter int NU = 4,                          // Units on the rack
    parameter logic [VW-1:0] HOST_VER = 8'h14,     // Arbitrary version value
    parameter int TICKS_US = CLK_MHZ               // Clocks per microsecond of the sync cycle
)(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic en_i,
    input wire logic [11:0] addr_i,
    input wire logic [DW-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DW-1:0] rdata_o,
    output logic irq_o,
    output logic [NU-1:0] solo_restart_o,
    sdl_if.host lnk
);
    // ************************************************************************
    // Registers
    // ************************************************************************
    typedef enum logic [1:0] {H_IDLE, H_SEND, H_WAIT} sdl_hst_e;
    sdl_hst_e st_r;
    logic [1:0] ctrl_r;                 // Enable and registered bits
    logic [15:0] cyc_us_r;              // Sync cycle in microseconds
    logic [AIW-1:0] in_ofs_r;           // Input part start, offset in the area
    logic [AIW-1:0] out_size_r;
    logic [AIW-1:0] in_size_r;
    logic [1:0] irq_st_r;
    logic [1:0] irq_mk_r;
    logic [CYC_CW-1:0] per_cnt_r;
    logic [AIW-1:0] idx_r;
    logic uerr_d_r;
    logic [DW-1:0] mem [AREA_WORDS];    // Shared area, words 1200 to 1295
    logic link_on;
    logic sync_now;
    logic in_area;
    logic [11:0] aofs;
    logic [CYC_CW-1:0] period;
    logic done_ev;
    logic uerr_ev;

    assign link_on = ctrl_r[CTRL_EN] & ctrl_r[CTRL_REG];
    assign period = CYC_CW'(cyc_us_r * TICKS_US);
    assign sync_now = link_on && (per_cnt_r == period - 1'b1);
    assign aofs = addr_i - 12'(AREA_FIRST);
    assign in_area = (addr_i >= 12'(AREA_FIRST)) && (addr_i <= 12'(AREA_LAST));
    assign done_ev = (st_r == H_WAIT) && lnk.in_vld && lnk.in_last;
    assign uerr_ev = lnk.unit_err & ~uerr_d_r;
    assign irq_o = |(irq_st_r & irq_mk_r);
    assign lnk.link_en = link_on;
    assign lnk.host_ver = HOST_VER;
    assign lnk.in_size = in_size_r;

    // Configuration; out-of-range values are ignored
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ctrl_r <= 2'h0;
            cyc_us_r <= CYC_RST_US;
            in_ofs_r <= IN_START_RST;
            out_size_r <= SIZE_RST;
            in_size_r <= SIZE_RST;
            irq_mk_r <= 2'h0;
        end
        else if (en_i && wr_i)
        begin
            case (addr_i)
                RA_CTRL: ctrl_r <= wdata_i[1:0];
                RA_CYCLE:
                    if (wdata_i >= 16'(CYC_MIN_US) && wdata_i <= 16'(CYC_MAX_US))
                        cyc_us_r <= wdata_i;
                RA_IN_START:
                    if (wdata_i > 16'(AREA_FIRST) && wdata_i <= 16'(AREA_LAST))
                        in_ofs_r <= AIW'(wdata_i - 16'(AREA_FIRST));
                RA_OUT_SIZE:
                    if (wdata_i <= 16'(in_ofs_r))
                        out_size_r <= AIW'(wdata_i);
                RA_IN_SIZE:
                    if (wdata_i <= 16'(IN_MAX) && wdata_i + 16'(in_ofs_r) <= 16'(AREA_WORDS))
                        in_size_r <= AIW'(wdata_i);
                RA_IRQ_MASK: irq_mk_r <= wdata_i[1:0];
                default: ;
            endcase
        end
    end

    // Fixed-interval sync pacing
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            per_cnt_r <= '0;
        else if (en_i)
            per_cnt_r <= (!link_on || sync_now) ? '0 : per_cnt_r + 1'b1;
    end

    // Exchange sequencer; a sync always restarts the exchange
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            st_r <= H_IDLE;
            idx_r <= '0;
            lnk.sync <= 1'b0;
            lnk.out_vld <= 1'b0;
            lnk.out_idx <= '0;
            lnk.out_dat <= '0;
            lnk.out_last <= 1'b0;
        end
        else if (en_i)
        begin
            lnk.sync <= sync_now;
            lnk.out_vld <= 1'b0;
            lnk.out_last <= 1'b0;
            if (sync_now)
            begin
                st_r <= (out_size_r != '0) ? H_SEND : H_WAIT;
                idx_r <= '0;
            end
            else
            begin
                case (st_r)
                    H_SEND:
                    begin
                        // First unit's output starts at the area base
                        lnk.out_vld <= 1'b1;
                        lnk.out_idx <= idx_r;
                        lnk.out_dat <= mem[idx_r];
                        lnk.out_last <= (idx_r == out_size_r - 1'b1);
                        idx_r <= idx_r + 1'b1;
                        if (idx_r == out_size_r - 1'b1)
                            st_r <= (in_size_r != '0) ? H_WAIT : H_IDLE;
                    end
                    H_WAIT: if (done_ev || !link_on) st_r <= H_IDLE;
                    H_IDLE: ;
                    default: st_r <= H_IDLE;
                endcase
            end
        end
    end

    // Shared area: link input words win over a software write
    always_ff @(posedge clk_i)
    begin
        if (en_i)
        begin
            if (st_r == H_WAIT && lnk.in_vld
                && (32'(in_ofs_r) + 32'(lnk.in_idx) < AREA_WORDS))
                mem[in_ofs_r + lnk.in_idx] <= lnk.in_dat;
            else if (wr_i && in_area)
                mem[aofs[AIW-1:0]] <= wdata_i;
        end
    end

    // Interrupt status, set wins over write-one-to-clear
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            irq_st_r <= 2'h0;
            uerr_d_r <= 1'b0;
        end
        else if (en_i)
        begin
            uerr_d_r <= lnk.unit_err;
            irq_st_r <= (irq_st_r & ~((wr_i && addr_i == RA_IRQ_STAT) ? wdata_i[1:0] : 2'h0))
                | {uerr_ev, done_ev};
        end
    end

    // Restart: collective while linked, single otherwise
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            lnk.restart <= 1'b0;
            solo_restart_o <= '0;
        end
        else if (en_i)
        begin
            lnk.restart <= wr_i && addr_i == RA_RESTART && link_on && (|wdata_i[NU-1:0]);
            solo_restart_o <= (wr_i && addr_i == RA_RESTART && !link_on) ? wdata_i[NU-1:0] : '0;
        end
    end

    // Read data one cycle after the strobe
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rdata_o <= '0;
        else if (en_i)
        begin
            rdata_o <= '0;
            if (rd_i && in_area)
                rdata_o <= mem[aofs[AIW-1:0]];
            else if (rd_i)
            begin
                case (addr_i)
                    RA_CTRL: rdata_o <= 16'(ctrl_r);
                    RA_CYCLE: rdata_o <= cyc_us_r;
                    RA_IN_START: rdata_o <= 16'(AREA_FIRST) + 16'(in_ofs_r);
                    RA_OUT_SIZE: rdata_o <= 16'(out_size_r);
                    RA_IN_SIZE: rdata_o <= 16'(in_size_r);
                    RA_STATUS: rdata_o <= 16'({st_r != H_IDLE, lnk.unit_err, lnk.unit_run});
                    RA_IRQ_STAT: rdata_o <= 16'(irq_st_r);
                    RA_IRQ_MASK: rdata_o <= 16'(irq_mk_r);
                    default: rdata_o <= '0;
                endcase
            end
        end
    end
endmodule // sdl_host
`default_nettype wire

// *** rtl/sdl_unit.sv ***
// Position unit end of the synchronous data link
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module sdl_unit
    import sdl_pkg::*;
#(
    parameter int AXES = 4,                 // Axes fed from the output region
    parameter int CTRL_CYCLES = CTRL_CYC    // Internal control cycle in clocks
)(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic en_i,
    sdl_if.unit lnk,
    input wire logic in_wr_i,                    // Stage one input word
    input wire logic [AIW-1:0] in_idx_i,
    input wire logic [DW-1:0] in_dat_i,
    input wire logic [AIW-1:0] feed_base_i,      // First word of axis 0 command
    output logic [2*DW-1:0] feed_cmd_o [AXES],   // Per-axis feeding command
    output logic feed_upd_o,                     // New commands, one cycle
    output logic ctrl_hold_o,                    // Internal control held off
    output logic ctrl_tick_o,                    // Internal cycle start, one cycle
    output logic dp_o,                           // Front display decimal point
    output logic run_o,
    output logic [3:0] err_o                     // Size, cycle, version, comm
);
    // ************************************************************************
    // State
    // ************************************************************************
    typedef enum logic [1:0] {U_IDLE, U_CAPT, U_SEND} sdl_ust_e;
    sdl_ust_e st_r;
    logic [DW-1:0] shadow [OUT_MAX];     // Words arriving in this exchange
    logic [DW-1:0] out_snap [OUT_MAX];   // Last committed output words
    logic [DW-1:0] in_mem [IN_MAX];      // Words staged by internal control
    logic [DW-1:0] in_snap [IN_MAX];     // Words being sent this exchange
    logic run_r;
    logic ver_err_r;
    logic cyc_err_r;
    logic size_err_r;
    logic comm_err_r;
    logic bad_r;                         // Current exchange saw a fault
    logic [AIW-1:0] exp_r;               // Next expected output index
    logic [AIW-1:0] cnt_r;               // Input word being sent
    logic [31:0] tick_cnt_r;
    logic [31:0] since_r;                // Clocks since last sync, saturating
    logic commit;
    logic fatal;
    logic ver_ok;
    logic size_ok;

    assign ver_ok = (lnk.host_ver >= VER_MIN);
    assign size_ok = (32'(lnk.in_size) <= IN_MAX);
    assign fatal = ver_err_r | cyc_err_r | size_err_r;
    assign commit = (st_r == U_CAPT) && lnk.out_vld && lnk.out_last;
    assign ctrl_hold_o = (st_r != U_IDLE);
    assign run_o = run_r;
    assign err_o = {size_err_r, cyc_err_r, ver_err_r, comm_err_r};
    assign lnk.unit_err = fatal | comm_err_r;
    assign lnk.unit_run = run_r;

    // ************************************************************************
    // Start-up, errors and restart
    // ************************************************************************
    // A restart pulse clears the run flag and every error flag; the host sends it to all units alike
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            run_r <= 1'b0;
            ver_err_r <= 1'b0;
            size_err_r <= 1'b0;
            dp_o <= 1'b0;
        end
        else if (en_i)
        begin
            if (lnk.restart)
            begin
                // Collective restart of the whole link
                run_r <= 1'b0;
                ver_err_r <= 1'b0;
                size_err_r <= 1'b0;
            end
            else
            begin
                if (lnk.link_en && !ver_ok)
                    ver_err_r <= 1'b1;
                if (lnk.link_en && !size_ok)
                    size_err_r <= 1'b1;
                // Refuse to start while any fatal error stands
                run_r <= lnk.link_en && ver_ok && size_ok && !fatal;
            end
            dp_o <= lnk.link_en && run_r;
        end
    end

    // Internal cycle runs free; a sync never realigns it
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            tick_cnt_r <= '0;
            ctrl_tick_o <= 1'b0;
        end
        else if (en_i)
        begin
            ctrl_tick_o <= (tick_cnt_r == 32'(CTRL_CYCLES - 1));
            tick_cnt_r <= (tick_cnt_r == 32'(CTRL_CYCLES - 1)) ? '0 : tick_cnt_r + 1'b1;
        end
    end

    // Sync closer than one internal cycle means the sync cycle is too short
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            since_r <= '1;
            cyc_err_r <= 1'b0;
        end
        else if (en_i)
        begin
            if (lnk.restart || !run_r)
                since_r <= '1;
            else if (lnk.sync)
                since_r <= '0;
            else if (since_r != '1)
                since_r <= since_r + 1'b1;
            if (lnk.restart)
                cyc_err_r <= 1'b0;
            else if (run_r && lnk.sync && since_r < 32'(CTRL_CYCLES - 1))
                cyc_err_r <= 1'b1;
        end
    end

    // ************************************************************************
    // Exchange sequencer
    // ************************************************************************
    // Capture all output words, commit, then send all input words
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            st_r <= U_IDLE;
            exp_r <= '0;
            cnt_r <= '0;
            bad_r <= 1'b0;
            comm_err_r <= 1'b0;
            lnk.in_vld <= 1'b0;
            lnk.in_idx <= '0;
            lnk.in_dat <= '0;
            lnk.in_last <= 1'b0;
        end
        else if (en_i)
        begin
            lnk.in_vld <= 1'b0;
            lnk.in_last <= 1'b0;
            if (lnk.restart || !run_r)
            begin
                st_r <= U_IDLE;
                comm_err_r <= comm_err_r & ~lnk.restart;
            end
            else if (lnk.sync)
            begin
                // Sync halts internal work and opens the exchange
                st_r <= U_CAPT;
                exp_r <= '0;
                bad_r <= (st_r != U_IDLE);  // Overrun of the last exchange
                comm_err_r <= comm_err_r | (st_r != U_IDLE);
            end
            else
            begin
                case (st_r)
                    U_CAPT:
                    begin
                        if (lnk.out_vld)
                        begin
                            exp_r <= exp_r + 1'b1;
                            if (lnk.out_idx != exp_r)
                            begin
                                bad_r <= 1'b1;
                                comm_err_r <= 1'b1;
                            end
                            if (lnk.out_last)
                            begin
                                cnt_r <= '0;
                                st_r <= (lnk.in_size != '0) ? U_SEND : U_IDLE;
                            end
                        end
                    end
                    U_SEND:
                    begin
                        lnk.in_vld <= 1'b1;
                        lnk.in_idx <= cnt_r;
                        lnk.in_dat <= in_snap[cnt_r[5:0]];
                        lnk.in_last <= (cnt_r == lnk.in_size - 1'b1);
                        cnt_r <= cnt_r + 1'b1;
                        if (cnt_r == lnk.in_size - 1'b1)
                            st_r <= U_IDLE;
                    end
                    U_IDLE: ;
                    default: st_r <= U_IDLE;
                endcase
            end
        end
    end

    // ************************************************************************
    // Data buffers
    // ************************************************************************
    // Staging by internal control; snapshot taken at commit unless faulted
    always_ff @(posedge clk_i)
    begin
        if (en_i)
        begin
            if (in_wr_i && 32'(in_idx_i) < IN_MAX)
                in_mem[in_idx_i[5:0]] <= in_dat_i;
            if (lnk.out_vld && st_r == U_CAPT)
                shadow[lnk.out_idx] <= lnk.out_dat;
            if (commit && !bad_r && lnk.out_idx == exp_r)
            begin
                for (int i = 0; i < IN_MAX; i++)
                    in_snap[i] <= in_mem[i];
                for (int i = 0; i < OUT_MAX; i++)
                    out_snap[i] <= (i == 32'(lnk.out_idx)) ? lnk.out_dat : shadow[i];
            end
            // A faulted exchange keeps the previous input snapshot
        end
    end

    // Update flag one cycle after a good commit
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            feed_upd_o <= 1'b0;
        else if (en_i)
            feed_upd_o <= commit && !bad_r && lnk.out_idx == exp_r;
    end

    // Per-axis feeding command, two words each, low word first
    for (genvar a = 0; a < AXES; a++)
    begin : g_axis
        logic [AIW-1:0] lo_idx;
        assign lo_idx = AIW'(feed_base_i + AIW'(2 * a));
        always_ff @(posedge clk_i or negedge rst_b_i)
        begin
            if (!rst_b_i)
                feed_cmd_o[a] <= '0;
            else if (en_i && feed_upd_o)
                feed_cmd_o[a] <= {out_snap[AIW'(lo_idx + 1'b1)], out_snap[lo_idx]};
        end
    end
endmodule // sdl_unit
`default_nettype wire

// *** testbench/sdl_monitor.sv ***
// Link protocol checker between host and position unit
`timescale 1ns/1ns
`default_nettype none
module sdl_monitor
    import sdl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic sync,
    input wire logic link_en,
    input wire logic restart,
    input wire logic [AIW-1:0] in_size,
    input wire logic out_vld,
    input wire logic [AIW-1:0] out_idx,
    input wire logic out_last,
    input wire logic in_vld,
    input wire logic [AIW-1:0] in_idx,
    input wire logic in_last,
    input wire logic unit_run
);
    // Reset quiets every check, so stale pre-reset history never fires
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    property p_sync_pulse; sync |=> !sync; endproperty
    a_sync_pulse: assert property (p_sync_pulse) else $error("sync too long");
    property p_sync_link; $rose(sync) |-> $past(link_en); endproperty
    a_sync_link: assert property (p_sync_link) else $error("sync while off");
    property p_out_start; sync |=> out_vld && out_idx == 7'h00; endproperty
    a_out_start: assert property (p_out_start) else $error("no output word");
    property p_out_seq;
        out_vld && !out_last |=> out_vld && out_idx == $past(out_idx) + 7'h01;
    endproperty
    a_out_seq: assert property (p_out_seq) else $error("output gap");
    // Unit's first input word comes two cycles after the last output word
    property p_in_start;
        out_vld && out_last && unit_run && in_size != 7'h00 |=> ##1 in_vld && in_idx == 7'h00;
    endproperty
    a_in_start: assert property (p_in_start) else $error("no input word");
    property p_in_seq;
        in_vld && !in_last |=> in_vld && in_idx == $past(in_idx) + 7'h01;
    endproperty
    a_in_seq: assert property (p_in_seq) else $error("input gap");
    property p_in_last;
        in_vld && in_last |-> in_idx == in_size - 7'h01 && in_idx < 7'h40;
    endproperty
    a_in_last: assert property (p_in_last) else $error("input count");
    property p_restart; restart |=> !unit_run; endproperty
    a_restart: assert property (p_restart) else $error("restart ignored");
endmodule // sdl_monitor
`default_nettype wire

// *** testbench/testbench.sv ***
// Testbench joining host and position unit over the link
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import sdl_pkg::*;
    logic clk_i = 1'b0, rst_b_i = 1'b0, en_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, in_wr_i = 1'b0;
    logic [11:0] addr_i = 12'h000;
    logic [DW-1:0] wdata_i = 16'h0000, in_dat_i = 16'h0000, rdata_o, d;
    logic [AIW-1:0] in_idx_i = 7'h00, feed_base_i = 7'h00;
    logic irq_o, dp_o, rs, run_o, ctrl_hold_o, hs = 1'b0;
    logic [3:0] solo_restart_o, err_o, so;
    logic [2*DW-1:0] feed_cmd_o [4];
    int num_errors = 0, n_tests = 0;
    // Register table rows: address beside its value after reset
    logic [11:0] ra [7] = '{RA_CTRL, RA_CYCLE, RA_IN_START, RA_OUT_SIZE, RA_IN_SIZE,
        RA_IRQ_MASK, 12'h0FF};
    logic [15:0] rv [7] = '{16'h0000, 16'h03E8, 16'h04E0, 16'h0008, 16'h0008, 16'h0000, 16'h0000};
    always #2 clk_i = ~clk_i;
    sdl_if lnk();
    // One clock per microsecond keeps the sync period short enough to simulate
    sdl_host #(.TICKS_US(1)) u_sdl_host (.clk_i, .rst_b_i, .en_i, .addr_i, .wdata_i, .wr_i,
        .rd_i, .rdata_o, .irq_o, .solo_restart_o, .lnk(lnk));
    sdl_unit #(.CTRL_CYCLES(20)) u_sdl_unit (.clk_i, .rst_b_i, .en_i, .lnk(lnk), .in_wr_i,
        .in_idx_i, .in_dat_i, .feed_base_i, .feed_cmd_o, .feed_upd_o(), .ctrl_hold_o,
        .ctrl_tick_o(), .dp_o, .run_o, .err_o);
    sdl_monitor u_sdl_monitor (.clk_i, .rst_b_i, .sync(lnk.sync), .link_en(lnk.link_en),
        .restart(lnk.restart), .in_size(lnk.in_size), .out_vld(lnk.out_vld), .out_idx(lnk.out_idx),
        .out_last(lnk.out_last), .in_vld(lnk.in_vld), .in_idx(lnk.in_idx), .in_last(lnk.in_last),
        .unit_run(lnk.unit_run));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One-cycle write strobe, released at the edge that took it
    task automatic wr(input logic [11:0] a, input logic [15:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    // Restart mask write, gathering every pulse that follows it
    task automatic pulses(input logic [15:0] m);
        so = 4'h0;
        rs = 1'b0;
        wr(RA_RESTART, m);
        repeat (3)
        begin
            #1 so = so | solo_restart_o;
            rs = rs | lnk.restart;
            @(posedge clk_i);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_b_i <= 1'b1;
        for (int i = 0; i < 7; i++)
        begin
            rd(ra[i]);
            chk("reset reg", d, rv[i]);
        end
        $display("test reset done");
        wr(RA_CYCLE, 16'h0064);
        rd(RA_CYCLE);
        chk("cycle", d, 16'h03E8);
        wr(RA_IN_SIZE, 16'h0041);
        rd(RA_IN_SIZE);
        chk("in size", d, 16'h0008);
        $display("test refuse done");
        // Area words for the host side, staged words for the unit side
        for (int i = 0; i < 8; i++)
        begin
            wr(12'(1200 + i), 16'(16'hA000 + i));
            in_wr_i <= 1'b1;
            in_idx_i <= 7'(i);
            in_dat_i <= 16'(16'h5000 + i);
        end
        @(posedge clk_i);
        in_wr_i <= 1'b0;
        wr(RA_IRQ_MASK, 16'h0001);
        wr(RA_CTRL, 16'h0003);
        repeat (3) @(posedge clk_i);
        chk("dp on", dp_o, 1'b1);
        chk("run", run_o, 1'b1);
        // Bounded wait for the first exchange, noting the control hold-off
        for (int k = 0; k < 2000 && irq_o !== 1'b1; k++)
        begin
            @(posedge clk_i);
            hs = hs | ctrl_hold_o;
        end
        chk("hold", hs, 1'b1);
        if (irq_o !== 1'b1)
        begin
            num_errors++;
            results();
        end
        for (int a = 0; a < 4; a++)
            chk("feed", feed_cmd_o[a], {16'(16'hA001 + 2 * a), 16'(16'hA000 + 2 * a)});
        for (int i = 0; i < 8; i++)
        begin
            rd(12'(1248 + i));
            chk("input word", d, 16'(16'h5000 + i));
        end
        chk("errors", err_o, 4'h0);
        wr(RA_IRQ_STAT, 16'h0001);
        #1 chk("irq clear", irq_o, 1'b0);
        $display("test exchange done");
        pulses(16'h0002);
        chk("solo linked", so, 4'h0);
        chk("all restart", rs, 1'b1);
        wr(RA_CTRL, 16'h0000);
        repeat (3) @(posedge clk_i);
        chk("dp off", dp_o, 1'b0);
        pulses(16'h0002);
        chk("solo unlinked", so, 4'h2);
        $display("test restart done");
        results();
    end
endmodule // testbench
`default_nettype wire
